// ===== cpu_tail_pkg.sv
// Constants, opcodes, register map and types for the tail-ops execution unit
package cpu_tail_pkg;
  // Register map, byte addresses on the AHB-Lite slave
  localparam logic [7:0] OFS_OP0 = 8'h00;
  localparam logic [7:0] OFS_OP1 = 8'h04;
  localparam logic [7:0] OFS_OP2 = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [1:0] GPR_WINDOW = 2'h1;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILLEGAL_BIT = 1;
  localparam int STAT_WDT_EN_BIT = 2;
  // Condition flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_B = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Opcodes
  localparam logic [7:0] OPB_WIDE_MUL = 8'hb0;
  localparam logic [15:0] OPW_UNLINK = 16'h0001;
  localparam logic [15:0] OPW_WDT = 16'hfff7;
  localparam logic [7:0] OPB_XOR_RR = 8'ha4;
  localparam logic [7:0] OPB_XOR_IDX = 8'h7c;
  localparam logic [7:0] OPB_XOR_DIR = 8'h74;
  localparam logic [11:0] OPP_XOR_I32 = 12'haac;
  localparam logic [11:0] OPP_XOR_U16 = 12'haa4;
  localparam logic [11:0] OPP_XOR_MI32 = 12'habc;
  localparam logic [11:0] OPP_XOR_MS16 = 12'had4;
  localparam logic [11:0] OPP_XOR_MW16 = 12'hab4;
  localparam logic [11:0] OPP_XOR_MB8 = 12'had9;
  localparam logic [2:0] SUB_XOR_B8 = 3'h4;
  localparam logic [2:0] SEL_QUAD_LOAD = 3'h4;
  localparam logic [2:0] SEL_QUAD_STORE = 3'h7;
  localparam logic [3:0] FP_IDX = 4'he;
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [31:0] SP_RELEASE_STEP = 32'h4;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_Q = 2'h2} opsize_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_MRD = 4'h4,
    ST_MWR = 4'h8
  } exec_state_t;
endpackage

// ===== xor_flag_eval.sv
// Sized exclusive-or with zero, sign and blank evaluation
`timescale 1ns/100ps
`default_nettype none
module xor_flag_eval (
  input wire logic [31:0] dst_i,
  input wire logic [31:0] src_i,
  input wire cpu_tail_pkg::opsize_t size_i,
  output logic [31:0] res_o,
  output logic zero_o,
  output logic sign_o,
  output logic blank_o
);
  wire [31:0] mask = (size_i == cpu_tail_pkg::SZ_B) ? 32'h0000_00ff :
                     (size_i == cpu_tail_pkg::SZ_W) ? 32'h0000_ffff : 32'hffff_ffff;
  wire [31:0] dst_m = dst_i & mask;
  wire [31:0] src_m = src_i & mask;
  assign res_o = dst_m ^ src_m;
  assign zero_o = (res_o == 32'h0);
  // Msb taken at the operand width, not at bit 31
  assign sign_o = (size_i == cpu_tail_pkg::SZ_B) ? res_o[7] :
                  (size_i == cpu_tail_pkg::SZ_W) ? res_o[15] : res_o[31];
  assign blank_o = (dst_m == 32'h0) || (src_m == 32'h0);
endmodule
`default_nettype wire

// ===== cpu_tail_ops_exec.sv
// Execution unit for unsigned multiply, frame release, watchdog refresh and exclusive-or
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module cpu_tail_ops_exec (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [1:0] mem_size_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic wdt_enable_o,
  output logic wdt_restart_o
);
  logic [31:0] gpr [16];
  logic [15:0] op_word [3];
  logic [7:0] flags;
  cpu_tail_pkg::exec_state_t state;
  cpu_tail_pkg::exec_state_t next_state;
  logic illegal;
  logic dp_write;
  logic dp_read;
  logic dp_map;
  logic [7:0] dp_addr;
  logic pend_unlink;
  logic pend_store;
  logic pend_signed;
  cpu_tail_pkg::opsize_t pend_size;
  logic [3:0] pend_reg;
  logic [31:0] pend_src;

  // Instruction fields
  wire [15:0] op0 = op_word[0];
  wire [15:0] op1 = op_word[1];
  wire [15:0] op2 = op_word[2];
  wire [3:0] rd_f = op0[3:0];
  wire [3:0] rs_f = op0[7:4];

  // Opcode decode
  wire is_wmul = (op0[15:8] == cpu_tail_pkg::OPB_WIDE_MUL);
  wire is_unlink = (op0 == cpu_tail_pkg::OPW_UNLINK);
  wire is_wdt = (op0 == cpu_tail_pkg::OPW_WDT);
  wire is_xrr = (op0[15:8] == cpu_tail_pkg::OPB_XOR_RR);
  wire is_xri32 = (op0[15:4] == cpu_tail_pkg::OPP_XOR_I32);
  wire is_xru16 = (op0[15:4] == cpu_tail_pkg::OPP_XOR_U16);
  wire is_xmi32 = (op0[15:4] == cpu_tail_pkg::OPP_XOR_MI32);
  wire is_xms16 = (op0[15:4] == cpu_tail_pkg::OPP_XOR_MS16);
  wire is_xmw16 = (op0[15:4] == cpu_tail_pkg::OPP_XOR_MW16);
  wire is_xmb8 = (op0[15:4] == cpu_tail_pkg::OPP_XOR_MB8) &&
                 (op1[10:8] == cpu_tail_pkg::SUB_XOR_B8);
  wire is_xdir = (op0[15:8] == cpu_tail_pkg::OPB_XOR_DIR);
  wire is_xidx = (op0[15:8] == cpu_tail_pkg::OPB_XOR_IDX);
  wire xor_reg = is_xrr || is_xri32 || is_xru16;
  wire xor_imm_mem = is_xmi32 || is_xms16 || is_xmw16 || is_xmb8;
  wire xor_mem = is_xdir || is_xidx || xor_imm_mem;
  wire known_op = is_wmul || is_unlink || is_wdt || xor_reg || xor_mem;

  // Size/direction selector shared by direct and indexed forms
  wire [2:0] mem_sel = is_xdir ? op0[6:4] : op1[15:13];
  wire sel_store = mem_sel[2] && (mem_sel[1] || mem_sel[0]);
  wire sel_quad = (mem_sel == cpu_tail_pkg::SEL_QUAD_LOAD) ||
                  (mem_sel == cpu_tail_pkg::SEL_QUAD_STORE);
  wire cpu_tail_pkg::opsize_t sel_size = sel_quad ? cpu_tail_pkg::SZ_Q :
                                         (mem_sel[1] ? cpu_tail_pkg::SZ_W : cpu_tail_pkg::SZ_B);
  wire mem_is_store = xor_imm_mem || ((is_xdir || is_xidx) && sel_store);
  wire cpu_tail_pkg::opsize_t imm_size = is_xmb8 ? cpu_tail_pkg::SZ_B :
                                         (is_xmw16 ? cpu_tail_pkg::SZ_W : cpu_tail_pkg::SZ_Q);
  wire cpu_tail_pkg::opsize_t issue_size = is_unlink ? cpu_tail_pkg::SZ_Q :
                                           (xor_imm_mem ? imm_size : sel_size);

  // Indexed stores use Rd as base and Rs as data; indexed loads the other way round
  wire [3:0] idx_base = sel_store ? rd_f : rs_f;
  wire [3:0] data_reg = (is_xidx && sel_store) ? rs_f : rd_f;

  // Effective addresses; short direct addresses reach the top and bottom 32K
  wire [31:0] addr_dir = op0[7] ? {op1, op2} : {{16{op1[15]}}, op1};
  wire [31:0] addr_idx = gpr[idx_base] + {{19{op1[12]}}, op1[12:0]};
  wire [31:0] issue_addr = is_unlink ? gpr[cpu_tail_pkg::FP_IDX] :
                           is_xdir ? addr_dir :
                           is_xidx ? addr_idx : gpr[rd_f];

  // Source for a memory destination
  wire [31:0] imm_src = is_xmi32 ? {op1, op2} :
                        is_xms16 ? {{16{op1[15]}}, op1} :
                        is_xmw16 ? {16'h0000, op1} : {24'h00_0000, op1[7:0]};
  wire [31:0] issue_src = xor_imm_mem ? imm_src : gpr[data_reg];

  // Register-destination source
  wire [31:0] reg_src = is_xrr ? gpr[rs_f] :
                        is_xri32 ? {op1, op2} : {16'h0000, op1};

  // Memory word extended to 32 bits for loads, trimmed for stores
  wire [31:0] ext_b = pend_signed ? {{24{mem_rdata_i[7]}}, mem_rdata_i[7:0]} :
                      {24'h00_0000, mem_rdata_i[7:0]};
  wire [31:0] ext_w = pend_signed ? {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]} :
                      {16'h0000, mem_rdata_i[15:0]};
  wire [31:0] mem_ext = (pend_size == cpu_tail_pkg::SZ_B) ? ext_b :
                        (pend_size == cpu_tail_pkg::SZ_W) ? ext_w : mem_rdata_i;

  // Multiply
  wire [63:0] product = gpr[rd_f] * gpr[rs_f];

  // State qualifiers
  wire in_exec = (state == cpu_tail_pkg::ST_EXEC);
  wire rd_done = (state == cpu_tail_pkg::ST_MRD) && mem_ack_i;
  wire wr_done = (state == cpu_tail_pkg::ST_MWR) && mem_ack_i;

  // Exclusive-or evaluator inputs; register targets always at 32 bits
  wire [31:0] xe_dst = in_exec ? gpr[rd_f] : (pend_store ? mem_ext : gpr[pend_reg]);
  wire [31:0] xe_src = in_exec ? reg_src : (pend_store ? pend_src : mem_ext);
  wire cpu_tail_pkg::opsize_t xe_size = (!in_exec && pend_store) ? pend_size :
                                        cpu_tail_pkg::SZ_Q;
  wire [31:0] xe_res;
  wire xe_zero;
  wire xe_sign;
  wire xe_blank;

  xor_flag_eval u_eval (
    .dst_i(xe_dst),
    .src_i(xe_src),
    .size_i(xe_size),
    .res_o(xe_res),
    .zero_o(xe_zero),
    .sign_o(xe_sign),
    .blank_o(xe_blank)
  );

  // Flag update: carry and both interrupt enables pass through untouched
  wire [7:0] xor_flags = {flags[7], xe_zero, xe_sign, 1'b0, xe_blank,
                          flags[2:0]};
  wire [7:0] mul_flags = {flags[7], (product == 64'h0), product[63], 1'b0, 1'b0,
                          flags[2:0]};
  wire flag_xor_we = (in_exec && xor_reg) || (rd_done && !pend_unlink);
  wire flag_mul_we = in_exec && is_wmul;

  // Register write ports; port b is applied after port a
  wire wa_en = (in_exec && (xor_reg || is_wmul)) || (rd_done && !pend_store);
  wire [3:0] wa_idx = (rd_done && pend_unlink) ? cpu_tail_pkg::SP_IDX :
                      (rd_done ? pend_reg : rd_f);
  wire [31:0] wa_data = (in_exec && is_wmul) ? product[31:0] :
                        (rd_done && pend_unlink) ?
                        gpr[cpu_tail_pkg::FP_IDX] + cpu_tail_pkg::SP_RELEASE_STEP :
                        xe_res;
  wire wb_en = (in_exec && is_wmul) || (rd_done && pend_unlink);
  wire [3:0] wb_idx = in_exec ? rs_f : cpu_tail_pkg::FP_IDX;
  wire [31:0] wb_data = in_exec ? product[63:32] : mem_rdata_i;

  // AHB-Lite slave; reads take one wait state so they see the last write
  wire ap_take = hsel_i && htrans_i[1] && hready_i;
  wire sw_wr = dp_write && dp_map && (state == cpu_tail_pkg::ST_IDLE);
  wire gpr_hit = dp_map && (dp_addr[7:6] == cpu_tail_pkg::GPR_WINDOW);
  wire wr_gpr = sw_wr && (dp_addr[7:6] == cpu_tail_pkg::GPR_WINDOW);
  wire wr_go = sw_wr && (dp_addr == cpu_tail_pkg::OFS_CTRL) &&
               hwdata_i[cpu_tail_pkg::CTRL_GO_BIT];
  wire busy = (state != cpu_tail_pkg::ST_IDLE);
  wire [31:0] status_word = {29'h0, wdt_enable_o, illegal, busy};
  wire [31:0] rd_mux = !dp_map ? 32'h0 :
                       gpr_hit ? gpr[dp_addr[5:2]] :
                       (dp_addr == cpu_tail_pkg::OFS_OP0) ? {16'h0000, op_word[0]} :
                       (dp_addr == cpu_tail_pkg::OFS_OP1) ? {16'h0000, op_word[1]} :
                       (dp_addr == cpu_tail_pkg::OFS_OP2) ? {16'h0000, op_word[2]} :
                       (dp_addr == cpu_tail_pkg::OFS_STATUS) ? status_word :
                       (dp_addr == cpu_tail_pkg::OFS_FLAGS) ? {24'h00_0000, flags} :
                       32'h0;

  assign hreadyout_o = !dp_read;
  assign hresp_o = cpu_tail_pkg::HRESP_OKAY;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_map <= 1'b0;
      dp_addr <= 8'h00;
      hrdata_o <= 32'h0;
    end
    else
    begin
      dp_write <= ap_take && hwrite_i;
      dp_read <= ap_take && !hwrite_i;
      if (ap_take)
      begin
        dp_map <= (haddr_i[31:8] == 24'h00_0000);
        dp_addr <= haddr_i[7:0];
      end
      if (dp_read)
      begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // Sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      cpu_tail_pkg::ST_IDLE:
      begin
        if (wr_go)
        begin
          next_state = cpu_tail_pkg::ST_EXEC;
        end
      end
      cpu_tail_pkg::ST_EXEC:
      begin
        next_state = (is_unlink || xor_mem) ? cpu_tail_pkg::ST_MRD : cpu_tail_pkg::ST_IDLE;
      end
      cpu_tail_pkg::ST_MRD:
      begin
        if (mem_ack_i)
        begin
          next_state = pend_store ? cpu_tail_pkg::ST_MWR : cpu_tail_pkg::ST_IDLE;
        end
      end
      cpu_tail_pkg::ST_MWR:
      begin
        if (mem_ack_i)
        begin
          next_state = cpu_tail_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_state = cpu_tail_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state <= cpu_tail_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Command words, flags and status
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      op_word[0] <= 16'h0000;
      op_word[1] <= 16'h0000;
      op_word[2] <= 16'h0000;
      flags <= cpu_tail_pkg::FLAGS_RESET;
      illegal <= 1'b0;
    end
    else
    begin
      if (sw_wr && (dp_addr == cpu_tail_pkg::OFS_OP0))
      begin
        op_word[0] <= hwdata_i[15:0];
      end
      if (sw_wr && (dp_addr == cpu_tail_pkg::OFS_OP1))
      begin
        op_word[1] <= hwdata_i[15:0];
      end
      if (sw_wr && (dp_addr == cpu_tail_pkg::OFS_OP2))
      begin
        op_word[2] <= hwdata_i[15:0];
      end
      // Frame release and watchdog refresh never reach these enables
      if (sw_wr && (dp_addr == cpu_tail_pkg::OFS_FLAGS))
      begin
        flags <= hwdata_i[7:0];
      end
      else if (flag_mul_we)
      begin
        flags <= mul_flags;
      end
      else if (flag_xor_we)
      begin
        flags <= xor_flags;
      end
      if (wr_go)
      begin
        illegal <= 1'b0;
      end
      else if (in_exec && !known_op)
      begin
        illegal <= 1'b1;
      end
    end
  end

  // Register file
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < 16; i++)
      begin
        gpr[i] <= 32'h0;
      end
    end
    else
    begin
      if (wr_gpr)
      begin
        gpr[dp_addr[5:2]] <= hwdata_i;
      end
      if (wa_en)
      begin
        gpr[wa_idx] <= wa_data;
      end
      if (wb_en)
      begin
        gpr[wb_idx] <= wb_data;
      end
    end
  end

  // Memory operand port: read, then write back for memory destinations
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0;
      mem_size_o <= cpu_tail_pkg::SZ_B;
      mem_wdata_o <= 32'h0;
      pend_unlink <= 1'b0;
      pend_store <= 1'b0;
      pend_signed <= 1'b0;
      pend_size <= cpu_tail_pkg::SZ_B;
      pend_reg <= 4'h0;
      pend_src <= 32'h0;
    end
    else if (in_exec && (is_unlink || xor_mem))
    begin
      mem_req_o <= 1'b1;
      mem_we_o <= 1'b0;
      mem_addr_o <= issue_addr;
      mem_size_o <= issue_size;
      pend_unlink <= is_unlink;
      pend_store <= mem_is_store && !is_unlink;
      pend_signed <= (is_xdir || is_xidx) && !mem_sel[2] && mem_sel[0];
      pend_size <= issue_size;
      pend_reg <= data_reg;
      pend_src <= issue_src;
    end
    else if (rd_done)
    begin
      mem_req_o <= pend_store;
      mem_we_o <= pend_store;
      mem_wdata_o <= xe_res;
    end
    else if (wr_done)
    begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
    end
  end

  // Watchdog: first refresh enables, later ones restart the time-out
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      wdt_enable_o <= 1'b0;
      wdt_restart_o <= 1'b0;
    end
    else
    begin
      wdt_restart_o <= in_exec && is_wdt && wdt_enable_o;
      if (in_exec && is_wdt)
      begin
        wdt_enable_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== cpu_tail_ops_exec_monitor.sv
// Port-level checker for the tail-ops execution unit
`timescale 1ns/100ps
`default_nettype none
module cpu_tail_ops_exec_monitor (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [1:0] mem_size_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic wdt_enable_o,
  input wire logic wdt_restart_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic taken = hsel_i && htrans_i[1] && hready_i;
  a_wdt_en_sticky:
    assert property (wdt_enable_o |=> wdt_enable_o) else $error("watchdog enable dropped");
  a_wdt_first_quiet:
    assert property ($rose(wdt_enable_o) |-> !wdt_restart_o) else $error("restart on enable");
  a_restart_needs_en:
    assert property (wdt_restart_o |-> $past(wdt_enable_o)) else $error("restart while off");
  a_restart_one_pulse:
    assert property (wdt_restart_o |=> !wdt_restart_o) else $error("restart pulse too long");
  a_mem_req_hold:
    assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_we_o) && $stable(mem_size_o)) else $error("memory request moved");
  a_mem_size_legal:
    assert property (mem_req_o |-> mem_size_o != 2'h3) else $error("bad memory size");
  a_byte_wdata_clean:
    assert property (mem_req_o && mem_we_o && mem_size_o == cpu_tail_pkg::SZ_B
      |-> mem_wdata_o[31:8] == 24'h0) else $error("byte store upper bits set");
  a_word_wdata_clean:
    assert property (mem_req_o && mem_we_o && mem_size_o == cpu_tail_pkg::SZ_W
      |-> mem_wdata_o[31:16] == 16'h0) else $error("word store upper bits set");
  // Read path is registered, so exactly one wait cycle is expected
  a_read_one_wait:
    assert property (taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait wrong");
  a_write_no_wait:
    assert property (taken && hwrite_i |=> hreadyout_o) else $error("write stalled");
  a_resp_okay:
    assert property (hresp_o == cpu_tail_pkg::HRESP_OKAY) else $error("response not okay");
  c_wdt_on: cover property ($rose(wdt_enable_o));
  c_wdt_restart: cover property (wdt_restart_o);
  c_mem_store: cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule
`default_nettype wire

// ===== cpu_tail_ops_exec_tb.sv
// Self-checking bench for the tail-ops execution unit
`timescale 1ns/100ps
`default_nettype none
module cpu_tail_ops_exec_tb;
  logic mclk_i, rst_b_i, hsel_i, hwrite_i, hready_i, mem_ack_i;
  logic [1:0] htrans_i, mem_size_o, rd_size, wr_size;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [31:0] mem_word, rd_addr, wr_addr, wr_data;
  logic hreadyout_o, hresp_o, mem_req_o, mem_we_o, wdt_enable_o, wdt_restart_o;
  int err_total, checks_done, cyc, mem_lat, wait_cnt, pulse_cnt, req_cnt;
  assign hready_i = hreadyout_o;
  cpu_tail_ops_exec cpu_tail_ops_exec_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_size_o(mem_size_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .wdt_enable_o(wdt_enable_o), .wdt_restart_o(wdt_restart_o));
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // Memory side; read data toggles when idle so stale values are never trusted
  always @(posedge mclk_i)
    if (mem_req_o === 1'b1 && mem_ack_i !== 1'b1 && wait_cnt >= mem_lat)
    begin
      mem_ack_i <= 1'b1;
      mem_rdata_i <= mem_word;
      wait_cnt <= 0;
      req_cnt <= req_cnt + 1;
      if (mem_we_o)
        {wr_addr, wr_data, wr_size} <= {mem_addr_o, mem_wdata_o, mem_size_o};
      else
        {rd_addr, rd_size} <= {mem_addr_o, mem_size_o};
    end
    else
    begin
      mem_ack_i <= 1'b0;
      mem_rdata_i <= ~mem_rdata_i;
      if (mem_req_o === 1'b1 && mem_ack_i !== 1'b1)
        wait_cnt <= wait_cnt + 1;
    end
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (wdt_restart_o === 1'b1)
      pulse_cnt <= pulse_cnt + 1;
    if (cyc == 20000)
    begin
      err_total++;
      final_report;
    end
  end
  task final_report;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_i);
    {hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, 2'h2, 24'h0, a, w};
    @(posedge mclk_i);
    while (hready_i !== 1'b1) @(posedge mclk_i);
    {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, d};
    @(posedge mclk_i);
    while (hready_i !== 1'b1) @(posedge mclk_i);
    r = hrdata_o;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  function automatic logic [7:0] gpr(input logic [3:0] n);
    return {2'h1, n, 2'h0};
  endfunction
  task run(input logic [15:0] o0, input logic [15:0] o1, input logic [15:0] o2);
    logic [31:0] s;
    wr(cpu_tail_pkg::OFS_OP0, {16'h0, o0});
    wr(cpu_tail_pkg::OFS_OP1, {16'h0, o1});
    wr(cpu_tail_pkg::OFS_OP2, {16'h0, o2});
    wr(cpu_tail_pkg::OFS_CTRL, 32'h1);
    s = 32'h1;
    while (s[0] !== 1'b0) ahb(1'b0, cpu_tail_pkg::OFS_STATUS, 32'h0, s);
  endtask
  task t_reset;
    rdchk(cpu_tail_pkg::OFS_FLAGS, {24'h0, cpu_tail_pkg::FLAGS_RESET});
    rdchk(cpu_tail_pkg::OFS_STATUS, 32'h0);
    wr(8'h80, 32'h1234_5678);
    rdchk(8'h80, 32'h0);
    wr(cpu_tail_pkg::OFS_FLAGS, 32'hfb);
    rdchk(cpu_tail_pkg::OFS_FLAGS, 32'hfb);
  endtask
  task automatic t_unsigned_wide_multiply;
    logic [31:0] a [4] = '{32'hffff_ffe5, 32'h8000_0000, 32'hffff_ffff, 32'h0};
    logic [31:0] b [4] = '{32'h5, 32'h2, 32'hffff_ffff, 32'h7};
    logic [31:0] lo [4] = '{32'hffff_ff79, 32'h0, 32'h1, 32'h0};
    logic [31:0] hi [4] = '{32'h4, 32'h1, 32'hffff_fffe, 32'h0};
    logic [7:0] fo [4] = '{8'h83, 8'h83, 8'ha3, 8'hc3};
    for (int i = 0; i < 4; i++)
    begin
      wr(gpr(4), a[i]);
      wr(gpr(5), b[i]);
      wr(cpu_tail_pkg::OFS_FLAGS, 32'h9b);
      run(16'hb054, 16'h0, 16'h0);
      rdchk(gpr(4), lo[i]);
      rdchk(gpr(5), hi[i]);
      rdchk(cpu_tail_pkg::OFS_FLAGS, {24'h0, fo[i]});
    end
  endtask
  task automatic t_xor_reg;
    logic [3:0] s [4] = '{4'he, 4'h2, 4'h2, 4'h2};
    logic [3:0] d [4] = '{4'h1, 4'h3, 4'h3, 4'h3};
    logic [31:0] vs [4] = '{32'h8d, 32'h0, 32'h8000_0000, 32'h8000_0001};
    logic [31:0] vd [4] = '{32'h38, 32'h5, 32'h8000_0000, 32'h1};
    logic [31:0] e [4] = '{32'hb5, 32'h5, 32'h0, 32'h8000_0000};
    logic [7:0] fi [4] = '{8'hd3, 8'h03, 8'h10, 8'h00};
    logic [7:0] fo [4] = '{8'h83, 8'h0b, 8'h40, 8'h20};
    for (int i = 0; i < 4; i++)
    begin
      wr(gpr(s[i]), vs[i]);
      wr(gpr(d[i]), vd[i]);
      wr(cpu_tail_pkg::OFS_FLAGS, {24'h0, fi[i]});
      run({8'ha4, s[i], d[i]}, 16'h0, 16'h0);
      rdchk(gpr(d[i]), e[i]);
      rdchk(gpr(s[i]), vs[i]);
      rdchk(cpu_tail_pkg::OFS_FLAGS, {24'h0, fo[i]});
    end
  endtask
  task t_xor_imm;
    wr(gpr(6), 32'h0);
    wr(cpu_tail_pkg::OFS_FLAGS, 32'h0);
    run(16'haac6, 16'h8000, 16'h0001);
    rdchk(gpr(6), 32'h8000_0001);
    rdchk(cpu_tail_pkg::OFS_FLAGS, 32'h28);
    wr(cpu_tail_pkg::OFS_FLAGS, 32'h90);
    run(16'haa46, 16'hffff, 16'h0);
    rdchk(gpr(6), 32'h8000_fffe);
    rdchk(cpu_tail_pkg::OFS_FLAGS, 32'ha0);
  endtask
  task automatic t_load;
    logic [15:0] o0 [4] = '{16'h7414, 16'h7404, 16'h74c4, 16'h7c54};
    logic [15:0] o1 [4] = '{16'hb07b, 16'hb07b, 16'h1234, 16'h6002};
    logic [31:0] mi [4] = '{32'hea, 32'hea, 32'h79, 32'h8001};
    logic [31:0] ea [4] = '{32'hffff_b07b, 32'hffff_b07b, 32'h1234_5678, 32'h1002};
    logic [1:0] sz [4] = '{2'h0, 2'h0, 2'h2, 2'h1};
    logic [31:0] e [4] = '{32'h93, 32'hffff_ff93, 32'hffff_ff00, 32'h7f78};
    logic [7:0] fo [4] = '{8'h00, 8'h20, 8'h20, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      {mem_lat, mem_word} = {i, mi[i]};
      wr(gpr(4), 32'hffff_ff79);
      wr(gpr(5), 32'h1000);
      wr(cpu_tail_pkg::OFS_FLAGS, 32'h0);
      run(o0[i], o1[i], 16'h5678);
      chk(rd_addr, ea[i]);
      chk({30'h0, rd_size}, {30'h0, sz[i]});
      rdchk(gpr(4), e[i]);
      rdchk(cpu_tail_pkg::OFS_FLAGS, {24'h0, fo[i]});
    end
  endtask
  task automatic t_store;
    logic [15:0] o0 [6] = '{16'hab4d, 16'had9d, 16'h7c5d, 16'habcd, 16'had4d, 16'h7475};
    logic [15:0] o1 [6] = '{16'h00f0, 16'h04aa, 16'hfffc, 16'h1234, 16'h8001, 16'h0100};
    logic [31:0] mi [6] = '{32'hc3f7, 32'haa, 32'h0, 32'hffff, 32'h8001, 32'h1};
    logic [31:0] ea [6] = '{32'hffff_b07a, 32'hffff_b07a, 32'hffff_b076, 32'hffff_b07a,
      32'hffff_b07a, 32'h100};
    logic [1:0] sz [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2};
    logic [31:0] e [6] = '{32'hc307, 32'h0, 32'h1000, 32'h1234_ffff, 32'hffff_0000, 32'h1001};
    logic [7:0] fo [6] = '{8'h20, 8'h40, 8'h08, 8'h00, 8'h20, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      {mem_lat, mem_word} = {32'h2, mi[i]};
      wr(gpr(13), 32'hffff_b07a);
      wr(cpu_tail_pkg::OFS_FLAGS, 32'h0);
      run(o0[i], o1[i], 16'h0);
      chk(wr_addr, ea[i]);
      chk({30'h0, wr_size}, {30'h0, sz[i]});
      chk(wr_data, e[i]);
      rdchk(cpu_tail_pkg::OFS_FLAGS, {24'h0, fo[i]});
    end
  endtask
  task t_unlink;
    {mem_lat, mem_word} = {32'h1, 32'habcd_0000};
    wr(gpr(14), 32'h1000);
    wr(gpr(15), 32'h2000);
    wr(cpu_tail_pkg::OFS_FLAGS, 32'hfb);
    run(16'h0001, 16'h0, 16'h0);
    chk(rd_addr, 32'h1000);
    rdchk(gpr(15), 32'h1004);
    rdchk(gpr(14), 32'habcd_0000);
    rdchk(cpu_tail_pkg::OFS_FLAGS, 32'hfb);
  endtask
  task t_wdt;
    chk({31'h0, wdt_enable_o}, 32'h0);
    wr(cpu_tail_pkg::OFS_FLAGS, 32'h5b);
    run(16'hfff7, 16'h0, 16'h0);
    chk({31'h0, wdt_enable_o}, 32'h1);
    chk(pulse_cnt, 0);
    rdchk(cpu_tail_pkg::OFS_STATUS, 32'h4);
    rdchk(cpu_tail_pkg::OFS_FLAGS, 32'h5b);
    run(16'hfff7, 16'h0, 16'h0);
    chk(pulse_cnt, 1);
    chk({31'h0, wdt_enable_o}, 32'h1);
  endtask
  task t_illegal;
    int n;
    n = req_cnt;
    run(16'had9d, 16'h06aa, 16'h0);
    rdchk(cpu_tail_pkg::OFS_STATUS, 32'h6);
    chk(req_cnt, n);
  endtask
  initial
  begin
    {rst_b_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i, hsize_i} = '0;
    {mem_ack_i, mem_rdata_i, mem_word, mem_lat, wait_cnt, req_cnt} = '0;
    {err_total, checks_done, cyc, pulse_cnt} = '0;
    hsize_i = 3'h2;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_unsigned_wide_multiply;
    t_xor_reg;
    t_xor_imm;
    t_load;
    t_store;
    t_unlink;
    t_wdt;
    t_illegal;
    final_report;
  end
endmodule
bind cpu_tail_ops_exec cpu_tail_ops_exec_monitor cpu_tail_ops_exec_monitor_i (.mclk_i(mclk_i),
  .rst_b_i(rst_b_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .wdt_enable_o(wdt_enable_o),
  .wdt_restart_o(wdt_restart_o));
`default_nettype wire
